// *** shared/port_irq_pkg.sv ***
// Package with register map, field positions and reset values of the port interrupt aggregator.
package port_irq_pkg;

	// Printed register indices; byte address on the bus is four times the index.
	localparam logic [7:0] IRQ_ENABLE_CTRL_IDX = 8'h23;
	localparam logic [7:0] IRQ_PENDING_STATUS_IDX = 8'h24;
	localparam logic [7:0] IRQ_EVENT_STATUS_IDX = 8'h30;
	localparam logic [7:0] IRQ_EVENT_MASK_IDX = 8'h31;

	// Byte addresses of the registers on the bus.
	localparam logic [11:0] IRQ_ENABLE_CTRL_ADDR = {2'h0, IRQ_ENABLE_CTRL_IDX, 2'h0};
	localparam logic [11:0] IRQ_PENDING_STATUS_ADDR = {2'h0, IRQ_PENDING_STATUS_IDX, 2'h0};
	localparam logic [11:0] IRQ_EVENT_STATUS_ADDR = {2'h0, IRQ_EVENT_STATUS_IDX, 2'h0};
	localparam logic [11:0] IRQ_EVENT_MASK_ADDR = {2'h0, IRQ_EVENT_MASK_IDX, 2'h0};

	// Field positions shared by the enable and pending registers.
	localparam int RX_PORT_LSB = 0;
	localparam int RX_PORT_MSB = 3;
	localparam int TX_PORT_BIT = 4;
	localparam int GLOBAL_BIT = 7;
	localparam int SOURCE_COUNT = 5;

	// Values after reset.
	localparam logic [7:0] IRQ_ENABLE_CTRL_RESET = 8'h00;
	localparam logic [4:0] EVENT_STATUS_RESET = 5'h00;
	localparam logic [4:0] EVENT_MASK_RESET = 5'h00;

	// Bus handshake states.
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK = 2'b10
	} bus_state_t;

endpackage

// *** hw/pending_flag.sv ***
// Sticky pending flag whose set wins over a clear in the same cycle.
`timescale 1ns/1ns
module pending_flag (
	input wire logic clk,
	input wire logic rstn,
	input wire logic setEvent,
	input wire logic clearEvent,
	output logic flag
);

	logic next_flag;

	// A new event keeps the flag set even when the clear arrives in the same cycle.
	always_comb begin
		next_flag = flag;
		if (clearEvent) begin
			next_flag = 1'b0;
		end
		if (setEvent) begin
			next_flag = 1'b1;
		end
	end

	// Flag register.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			flag <= 1'b0;
		end else begin
			flag <= next_flag;
		end
	end

endmodule

// *** hw/port_irq_aggregator.sv ***
// Interrupt aggregator for four receive ports and one transmit port, with an APB slave.
`timescale 1ns/1ns

// Function
// - Interrupt output irqOut only while global enable set; eventIrq ignores it.
// - Per receive port enable bits 0..3.
// - Transmit port enable at bit 4.
// - Summary bit 7 set when enabled source pending.
// - Summary ignores the global enable bit.
// - Receive event sets its pending bit.
// - Receive pending clears on port status read.
// - Transmit pending set by event, cleared by read.
// - All enables cleared by reset.
module port_irq_aggregator
	import port_irq_pkg::*;
#(
	parameter int ADDR_WIDTH = 12,
	parameter int RX_PORTS = 4
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_WIDTH-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [RX_PORTS-1:0] rxPortEvent,
	input wire logic [RX_PORTS-1:0] rxPortStatusRead,
	input wire logic txPortEvent,
	input wire logic txPortStatusRead,
	output logic irqOut,
	output logic eventIrq
);

	// Control register fields.
	logic globalIrqEnable;
	logic [RX_PORTS-1:0] rxPortIrqEnable;
	logic txPortIrqEnable;
	logic next_globalIrqEnable;
	logic [RX_PORTS-1:0] next_rxPortIrqEnable;
	logic next_txPortIrqEnable;

	// Pending flags and the derived summary.
	logic [RX_PORTS-1:0] rxPortIrqPending;
	logic txPortIrqPending;
	logic summaryIrq;

	// Sticky event status and its mask.
	logic [SOURCE_COUNT-1:0] eventStatus;
	logic [SOURCE_COUNT-1:0] eventMask;
	logic [SOURCE_COUNT-1:0] next_eventStatus;
	logic [SOURCE_COUNT-1:0] next_eventMask;
	logic [SOURCE_COUNT-1:0] sourceEvent;

	// Bus handshake state and answer registers.
	bus_state_t busState;
	bus_state_t next_busState;
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	logic next_irqOut;
	logic next_eventIrq;

	// Address decode and transfer qualifiers.
	logic [11:0] byteAddr;
	logic hitEnableCtrl;
	logic hitPendingStatus;
	logic hitEventStatus;
	logic hitEventMask;
	logic hitAny;
	logic setupPhase;
	logic writeCommit;
	logic [7:0] pendingStatusValue;
	logic [7:0] enableCtrlValue;
	logic accessPhase;
	logic readRequest;

	// Write strobes, the gathered source bits and the read word.
	logic writeEnableCtrl;
	logic writeEventStatus;
	logic writeEventMask;
	logic [SOURCE_COUNT-1:0] eventStatusClear;
	logic [SOURCE_COUNT-1:0] sourcePending;
	logic [SOURCE_COUNT-1:0] sourceEnable;
	logic [SOURCE_COUNT-1:0] eventActive;
	logic [3:0] hitVector;
	logic [31:0] readWord;

	// Bring the bus address to the width of the map constants.
	assign byteAddr = 12'(paddr);

	// Decode which register the current transfer addresses.
	always_comb begin
		hitEnableCtrl = (byteAddr == IRQ_ENABLE_CTRL_ADDR);
		hitPendingStatus = (byteAddr == IRQ_PENDING_STATUS_ADDR);
		hitEventStatus = (byteAddr == IRQ_EVENT_STATUS_ADDR);
		hitEventMask = (byteAddr == IRQ_EVENT_MASK_ADDR);
		hitAny = hitEnableCtrl | hitPendingStatus | hitEventStatus | hitEventMask;
	end

	// The setup phase starts a transfer; a write commits on the completing access edge.
	assign setupPhase = psel & ~penable;
	assign accessPhase = psel & penable;
	assign readRequest = setupPhase & ~pwrite;
	assign writeCommit = accessPhase & pready & pwrite & hitAny;

	// One strobe per writable register; the clear mask stays zero unless status is written.
	always_comb begin
		writeEnableCtrl = writeCommit & hitEnableCtrl;
		writeEventStatus = writeCommit & hitEventStatus;
		writeEventMask = writeCommit & hitEventMask;
		eventStatusClear = {SOURCE_COUNT{1'b0}};
		if (writeEventStatus) begin
			eventStatusClear = pwdata[SOURCE_COUNT-1:0];
		end
	end

	// One pending flag per receive port, set by its event, cleared by its status read.
	genvar gi;
	generate
		for (gi = 0; gi < RX_PORTS; gi++) begin : gen_rx_pending
			pending_flag u_rx_pending (
				.clk(clk),
				.rstn(rstn),
				.setEvent(rxPortEvent[gi]),
				.clearEvent(rxPortStatusRead[gi]),
				.flag(rxPortIrqPending[gi])
			);
		end
	endgenerate

	// Transmit port pending flag, cleared when its interrupt status is read.
	pending_flag u_tx_pending (
		.clk(clk),
		.rstn(rstn),
		.setEvent(txPortEvent),
		.clearEvent(txPortStatusRead),
		.flag(txPortIrqPending)
	);

	// Pending and enable bits gathered in register order, transmit port on top.
	always_comb begin
		sourcePending = {txPortIrqPending, rxPortIrqPending};
		sourceEnable = {txPortIrqEnable, rxPortIrqEnable};
	end

	// Summary is any pending source whose own enable is set, independent of the global bit.
	always_comb begin
		summaryIrq = |(sourcePending & sourceEnable);
	end

	// Pending status image as software sees it; reserved bits read as zero.
	always_comb begin
		pendingStatusValue = 8'h00;
		pendingStatusValue[GLOBAL_BIT] = summaryIrq;
		pendingStatusValue[RX_PORT_MSB:RX_PORT_LSB] = rxPortIrqPending;
		pendingStatusValue[TX_PORT_BIT] = txPortIrqPending;
	end

	// Enable register image; the two reserved bits read as zero.
	always_comb begin
		enableCtrlValue = 8'h00;
		enableCtrlValue[GLOBAL_BIT] = globalIrqEnable;
		enableCtrlValue[RX_PORT_MSB:RX_PORT_LSB] = rxPortIrqEnable;
		enableCtrlValue[TX_PORT_BIT] = txPortIrqEnable;
	end

	// Software writes to the enable register steer the summary and the output.
	always_comb begin
		next_globalIrqEnable = globalIrqEnable;
		next_rxPortIrqEnable = rxPortIrqEnable;
		next_txPortIrqEnable = txPortIrqEnable;
		if (writeEnableCtrl) begin
			next_globalIrqEnable = pwdata[GLOBAL_BIT];
			next_rxPortIrqEnable = pwdata[RX_PORT_MSB:RX_PORT_LSB];
			next_txPortIrqEnable = pwdata[TX_PORT_BIT];
		end
	end

	// Enable register; every enable starts cleared.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			globalIrqEnable <= IRQ_ENABLE_CTRL_RESET[GLOBAL_BIT];
			rxPortIrqEnable <= IRQ_ENABLE_CTRL_RESET[RX_PORT_MSB:RX_PORT_LSB];
			txPortIrqEnable <= IRQ_ENABLE_CTRL_RESET[TX_PORT_BIT];
		end else begin
			globalIrqEnable <= next_globalIrqEnable;
			rxPortIrqEnable <= next_rxPortIrqEnable;
			txPortIrqEnable <= next_txPortIrqEnable;
		end
	end

	// Each source event sets its sticky bit; writing a one clears it, but a new event wins.
	always_comb begin
		sourceEvent = {txPortEvent, rxPortEvent};
		next_eventStatus = eventStatus;
		next_eventMask = eventMask;
		next_eventStatus = eventStatus & ~eventStatusClear;
		if (writeEventMask) begin
			next_eventMask = pwdata[SOURCE_COUNT-1:0];
		end
		next_eventStatus = next_eventStatus | sourceEvent;
	end

	// Event status and mask registers.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			eventStatus <= EVENT_STATUS_RESET;
			eventMask <= EVENT_MASK_RESET;
		end else begin
			eventStatus <= next_eventStatus;
			eventMask <= next_eventMask;
		end
	end

	// Both interrupt outputs are refreshed on every clock.
	always_comb begin
		next_irqOut = globalIrqEnable & summaryIrq;
		eventActive = eventStatus & eventMask;
		next_eventIrq = |eventActive;
	end

	// Interrupt output registers.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irqOut <= 1'b0;
			eventIrq <= 1'b0;
		end else begin
			irqOut <= next_irqOut;
			eventIrq <= next_eventIrq;
		end
	end

	// Read word for the addressed register, taken as a snapshot at the setup edge.
	always_comb begin
		hitVector = {hitEventMask, hitEventStatus, hitPendingStatus, hitEnableCtrl};
		readWord = 32'h0000_0000;
		if (readRequest) begin
			case (hitVector)
				4'b0001: begin
					readWord = {24'h00_0000, enableCtrlValue};
				end
				4'b0010: begin
					readWord = {24'h00_0000, pendingStatusValue};
				end
				4'b0100: begin
					readWord = {27'h000_0000, eventStatus};
				end
				4'b1000: begin
					readWord = {27'h000_0000, eventMask};
				end
				default: begin
					// Unmapped reads return zero alongside the error answer.
					readWord = 32'h0000_0000;
				end
			endcase
		end
	end

	// Bus handshake: read data is captured at the setup edge, and pready rises on that same edge.
	always_comb begin
		next_busState = busState;
		next_pready = 1'b0;
		next_pslverr = 1'b0;
		next_prdata = prdata;
		case (busState)
			BUS_IDLE: begin
				if (setupPhase) begin
					next_busState = BUS_ACK;
					next_pready = 1'b1;
					next_pslverr = ~hitAny;
					next_prdata = readWord;
				end
			end
			BUS_ACK: begin
				// The access completes on this edge; return to idle for the next setup.
				next_busState = BUS_IDLE;
			end
			default: begin
				next_busState = BUS_IDLE;
			end
		endcase
	end

	// Bus handshake registers.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			busState <= BUS_IDLE;
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			busState <= next_busState;
			pready <= next_pready;
			pslverr <= next_pslverr;
			prdata <= next_prdata;
		end
	end

endmodule

// *** dv/port_irq_aggregator_asserts.sv ***
// Checker for the port interrupt aggregator, bound to its ports.
`timescale 1ns/1ns
module port_irq_aggregator_asserts
	import port_irq_pkg::*;
#(
	parameter int ADDR_WIDTH = 12,
	parameter int RX_PORTS = 4
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_WIDTH-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [RX_PORTS-1:0] rxPortEvent,
	input wire logic [RX_PORTS-1:0] rxPortStatusRead,
	input wire logic txPortEvent,
	input wire logic txPortStatusRead,
	input wire logic irqOut,
	input wire logic eventIrq
);
	logic [7:0] en;
	logic [7:0] next_en;
	logic [4:0] pend;
	logic [4:0] next_pend;
	logic sum;
	logic mapped;
	// Shadow of the enables and pending bits; a set beats a clear.
	always_comb begin
		next_en = en;
		if (psel && penable && pready && pwrite && paddr == IRQ_ENABLE_CTRL_ADDR) begin
			next_en = pwdata[7:0] & 8'h9F;
		end
		next_pend = (pend & ~{txPortStatusRead, rxPortStatusRead}) | {txPortEvent, rxPortEvent};
	end
	// Registers the shadow state.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			en <= 8'h00;
			pend <= 5'h00;
		end else begin
			en <= next_en;
			pend <= next_pend;
		end
	end
	assign sum = |(en[4:0] & pend);
	assign mapped = paddr inside {IRQ_ENABLE_CTRL_ADDR, IRQ_PENDING_STATUS_ADDR,
		IRQ_EVENT_STATUS_ADDR, IRQ_EVENT_MASK_ADDR};
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	irq_follow_a: assert property (irqOut == $past(en[7] & sum))
		else $error("interrupt output differs from global enable and summary");
	ready_answer_a: assert property (psel && !penable |=> pready)
		else $error("no ready in the access cycle");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	err_unmapped_a: assert property (pready && !mapped |-> pslverr)
		else $error("unmapped access without error");
	err_mapped_a: assert property (pready && mapped |-> !pslverr)
		else $error("mapped access with error");
	err_quiet_a: assert property (!pready |-> !pslverr)
		else $error("error outside a ready cycle");
	ctrl_read_a: assert property (
		pready && !pwrite && paddr == IRQ_ENABLE_CTRL_ADDR
		|-> prdata == {24'h000000, $past(en)})
		else $error("enable register read wrong");
	pend_read_a: assert property (
		pready && !pwrite && paddr == IRQ_PENDING_STATUS_ADDR
		|-> prdata == {24'h000000, $past(sum), 2'h0, $past(pend)})
		else $error("pending register read wrong");
endmodule
bind port_irq_aggregator port_irq_aggregator_asserts #(.ADDR_WIDTH(ADDR_WIDTH),
	.RX_PORTS(RX_PORTS)) chk (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .rxPortEvent(rxPortEvent), .rxPortStatusRead(rxPortStatusRead),
	.txPortEvent(txPortEvent), .txPortStatusRead(txPortStatusRead), .irqOut(irqOut),
	.eventIrq(eventIrq));

// *** dv/port_event_source.sv ***
// Model of the port blocks that raise events and see their status registers read.
`timescale 1ns/1ns
module port_event_source (
	input wire logic clk,
	output logic [3:0] rxPortEvent,
	output logic [3:0] rxPortStatusRead,
	output logic txPortEvent,
	output logic txPortStatusRead
);
	logic [4:0] ev = 5'h00;
	logic [4:0] rd = 5'h00;
	// Bit 4 is the transmit port, bits 3 to 0 the receive ports.
	assign rxPortEvent = ev[3:0];
	assign txPortEvent = ev[4];
	assign rxPortStatusRead = rd[3:0];
	assign txPortStatusRead = rd[4];
	// Raises events and status reads for one cycle.
	task automatic pulse(input logic [4:0] e, input logic [4:0] r);
		ev <= e;
		rd <= r;
		@(posedge clk);
		ev <= 5'h00;
		rd <= 5'h00;
	endtask
endmodule

// *** dv/port_irq_aggregator_tb.sv ***
// Testbench for the port interrupt aggregator.
`timescale 1ns/1ns
module port_irq_aggregator_tb
	import port_irq_pkg::*;
;
	logic clk, rstn, psel, penable, pwrite, pready, pslverr, irqOut, eventIrq, txEv, txRd;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] rxEv, rxRd;
	logic er;
	int fails, num_checks;
	localparam logic [11:0] CTL = IRQ_ENABLE_CTRL_ADDR;
	localparam logic [11:0] PND = IRQ_PENDING_STATUS_ADDR;
	port_irq_aggregator dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rxPortEvent(rxEv), .rxPortStatusRead(rxRd), .txPortEvent(txEv),
		.txPortStatusRead(txRd), .irqOut(irqOut), .eventIrq(eventIrq));
	port_event_source src (.clk(clk), .rxPortEvent(rxEv), .rxPortStatusRead(rxRd),
		.txPortEvent(txEv), .txPortStatusRead(txRd));
	// Prints the counts and the verdict, then ends the run.
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Compares a seen value with the expected one.
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// One bus transfer; entered just after a rising edge.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			fails++;
			conclude();
		end else begin
			rd = prdata;
			er = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			// One idle edge keeps a following call from driving the strobes twice at once.
			@(posedge clk);
		end
	endtask
	// Free-running clock.
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Main sequence.
	initial begin
		{rstn, psel, penable, pwrite, paddr, pwdata, fails, num_checks} = '0;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		apb(0, CTL, 0);
		chk("ctrl reset", rd, 32'h0);
		apb(1, CTL, 32'hFF);
		apb(0, CTL, 0);
		chk("ctrl rw", rd, 32'h9F);
		apb(1, PND, 32'hFF);
		apb(0, PND, 0);
		chk("pend ro", rd, 32'h0);
		apb(0, 12'h004, 0);
		chk("unmapped err", 32'(er), 32'h1);
		chk("unmapped data", rd, 32'h0);
		for (int i = 0; i < 5; i++) begin
			apb(1, CTL, 32'h1F);
			src.pulse(5'(1 << i), 5'h00);
			apb(0, PND, 0);
			chk("pend", rd, 32'h80 | (1 << i));
			chk("irq off", 32'(irqOut), 32'h0);
			apb(1, CTL, 32'h9F & ~(1 << i));
			apb(0, PND, 0);
			chk("pend gated", rd, 32'(1 << i));
			chk("irq gated", 32'(irqOut), 32'h0);
			apb(1, CTL, 32'h9F);
			repeat (2) @(posedge clk);
			chk("irq on", 32'(irqOut), 32'h1);
			src.pulse(5'h00, 5'(1 << i));
			apb(0, PND, 0);
			chk("pend clr", rd, 32'h0);
			chk("irq clr", 32'(irqOut), 32'h0);
		end
		src.pulse(5'h01, 5'h01);
		apb(0, PND, 0);
		chk("set wins", rd, 32'h81);
		apb(0, IRQ_EVENT_STATUS_ADDR, 0);
		chk("evt status", rd, 32'h1F);
		apb(1, IRQ_EVENT_MASK_ADDR, 32'h1F);
		repeat (2) @(posedge clk);
		chk("evt irq on", 32'(eventIrq), 32'h1);
		apb(1, IRQ_EVENT_MASK_ADDR, 0);
		repeat (2) @(posedge clk);
		chk("evt irq masked", 32'(eventIrq), 32'h0);
		apb(1, IRQ_EVENT_MASK_ADDR, 32'h1F);
		apb(1, IRQ_EVENT_STATUS_ADDR, 32'h1F);
		apb(0, IRQ_EVENT_STATUS_ADDR, 0);
		chk("evt cleared", rd, 32'h0);
		chk("evt irq clr", 32'(eventIrq), 32'h0);
		// A reset in mid-run clears every enable, so a new event cannot raise the output.
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		chk("irq reset", 32'(irqOut), 32'h0);
		apb(0, CTL, 0);
		chk("ctrl re-reset", rd, 32'h0);
		src.pulse(5'h01, 5'h00);
		repeat (2) @(posedge clk);
		chk("irq disabled", 32'(irqOut), 32'h0);
		apb(0, PND, 0);
		chk("pend no enable", rd, 32'h1);
		conclude();
	end
endmodule
